//--- rtl/rdds_top.sv
// Receiver data sequencer: sleep, wake and receive sequencing, debounce
// of the demodulator output and a two-entry output buffer.
// Assumes mclk is the crystal clock; all other inputs are asynchronous pins
// except clk_en and out_ready, which come from logic on mclk.
// Contract
// - Two select pins decode to range 0, 1 or 2; both high also gives 2.
// - Extended tick spans 8, 4, 2 or 1 base ticks for ranges 0 to 3.
// - All timing comes from one base tick divided from the crystal clock.
// - Base divider is 10 with band low and 14 with band high.
// - Divider gives about 2.04 or 2.07 microsecond base ticks.
// - Enable low keeps the block asleep, ignoring the demodulator.
// - Enable high starts a wake period whose length depends on range.
// - After the wake period the block enters receive mode.
// - In receive mode the processed demodulator level drives the data pin.
// - Output stream starts on a falling edge of the demodulator signal.
// - Receive mode lasts until enable falls, then back to sleep.
// - Demodulator sampled on extended ticks, or when space frees after a tick met a full buffer; output level changes only then.
// - Output edges closer than the minimum spacing are suppressed.
// - Low-pass corner setting follows the decoded rate range.
`timescale 1ns/1ps
module rdds_top
   import rdds_pkg::*;
#(
   parameter logic [3:0] MIN_EE_TICKS = MIN_EE_DEF
)(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic        band_sel,
   input  wire logic        rate_sel_hi,
   input  wire logic        rate_sel_lo,
   input  wire logic        enable,
   input  wire logic        dem_in,
   input  wire logic        out_ready,
   output logic             data_out,
   output logic             out_valid,
   output logic             rx_active,
   output rdds_range_t      lp_corner
);

   rdds_tick_if tk ();

   logic [4:0]  sync1_q;
   logic [4:0]  sync2_q;
   logic        band_s;
   logic        hi_s;
   logic        lo_s;
   logic        en_s;
   logic        dem_s;
   rdds_range_t range_q;
   rdds_state_e state_q;
   rdds_state_e state_d;
   logic [9:0]  wake_cnt_q;
   logic        wake_done;
   logic        pend_q;
   logic        step;
   logic        stay_rx;
   logic        armed_q;
   logic        arm;
   logic        prev_q;
   logic        lvl_q;
   logic        lvl_d;
   logic [3:0]  gap_q;
   logic        push;
   logic        pop;
   logic        in_rdy;
   logic [1:0]  mem_q;
   logic        wr_q;
   logic        rd_q;
   logic [1:0]  cnt_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else if (clk_en) begin
         sync1_q <= {band_sel, rate_sel_hi, rate_sel_lo, enable, dem_in};
         sync2_q <= sync1_q;
      end
   end

   assign {band_s, hi_s, lo_s, en_s, dem_s} = sync2_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         range_q <= RANGE_RST;
      end else if (clk_en) begin
         range_q <= hi_s ? 2'h2 : {1'b0, lo_s};
      end
   end

   assign lp_corner = range_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Tick generation
   assign tk.band  = band_s;
   assign tk.run   = en_s;
   assign tk.range = range_q;

   rdds_tick_gen u_tick (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .clk_en (clk_en),
      .tk     (tk)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Sleep, wake and receive sequencing
   assign wake_done = tk.base_tick && (wake_cnt_q >= rdds_wake_term(range_q) - 10'h1);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_SLEEP: if (en_s) state_d = ST_WAKE;
         ST_WAKE: begin
            if (!en_s) begin
               state_d = ST_SLEEP;
            end else if (wake_done) begin
               state_d = ST_RX;
            end
         end
         ST_RX:    if (!en_s) state_d = ST_SLEEP;
         default:  state_d = ST_SLEEP;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_SLEEP;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wake_cnt_q <= 10'h000;
      end else if (clk_en) begin
         if (state_q != ST_WAKE) begin
            wake_cnt_q <= 10'h000;
         end else if (tk.base_tick) begin
            wake_cnt_q <= wake_cnt_q + 10'h001;
         end
      end
   end

   assign rx_active = (state_q == ST_RX);

   ////////////////////////////////////////////////////////////////////////////////
   // Sampling and debounce
   // Flush on the same edge that leaves receive mode, so nothing leaks into sleep
   assign stay_rx = (state_d == ST_RX);
   // A tick seen while the buffer is full waits; later ticks before space frees merge into it
   assign step = rx_active & (tk.ext_tick | pend_q) & in_rdy;
   assign arm  = step & ~armed_q & prev_q & ~dem_s;

   always_comb begin
      lvl_d = lvl_q;
      if (arm) begin
         lvl_d = 1'b0;
      end else if (step && armed_q && dem_s != lvl_q
                   && gap_q >= MIN_EE_TICKS - 4'h1) begin
         lvl_d = dem_s;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
      end else if (clk_en) begin
         pend_q <= stay_rx & rx_active & (tk.ext_tick | pend_q) & ~in_rdy;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
         prev_q  <= 1'b0;
         lvl_q   <= IDLE_LVL;
         gap_q   <= 4'h0;
      end else if (clk_en) begin
         if (!stay_rx) begin
            armed_q <= 1'b0;
            prev_q  <= 1'b0;
            lvl_q   <= IDLE_LVL;
            gap_q   <= 4'h0;
         end else if (step) begin
            armed_q <= armed_q | arm;
            prev_q  <= dem_s;
            lvl_q   <= lvl_d;
            if (lvl_d != lvl_q) begin
               gap_q <= 4'h0;
            end else if (gap_q != 4'hf) begin
               gap_q <= gap_q + 4'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Two-entry output buffer
   assign push      = step & (armed_q | arm);
   assign in_rdy    = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign pop       = out_valid & out_ready;
   assign data_out  = out_valid ? mem_q[rd_q] : lvl_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mem_q <= 2'h0;
      end else if (clk_en && push) begin
         mem_q[wr_q] <= lvl_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else if (clk_en) begin
         if (!stay_rx) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
         end else begin
            wr_q  <= wr_q ^ push;
            rd_q  <= rd_q ^ pop;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_RANGE_DECODE: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && hi_s) |=> (!clk_en || lp_corner == 2'h2))
      else $error("select high did not decode to range 2");

   AST_SLEEP_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_q != ST_RX) |-> (data_out == IDLE_LVL && !out_valid && !push))
      else $error("output active outside receive mode");

   AST_WAKE_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(rx_active) |-> $past(wake_cnt_q) == rdds_wake_term(range_q) - 10'h1)
      else $error("wake period length wrong");

   AST_WAKE_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && state_q == ST_SLEEP && en_s) |=> state_q == ST_WAKE && wake_cnt_q == 10'h0)
      else $error("enable rise did not start wake period");

   AST_DROP_TO_SLEEP: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && !en_s) |=> state_q == ST_SLEEP)
      else $error("enable low did not return to sleep");

   AST_FIRST_FALL: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(armed_q) |-> $past(prev_q) && !$past(dem_s) && !lvl_q)
      else $error("stream did not start on falling edge");

   AST_TICK_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && lvl_d != lvl_q) |-> step)
      else $error("output level changed off a tick");

   AST_MIN_EDGE: assert property (@(posedge mclk) disable iff (!rst_n)
      (clk_en && armed_q && lvl_d != lvl_q) |-> gap_q >= MIN_EE_TICKS - 4'h1)
      else $error("output edges closer than minimum");

   AST_NO_OVERFLOW: assert property (@(posedge mclk) disable iff (!rst_n)
      (cnt_q == 2'h2) |-> !push)
      else $error("buffer written while full");

endmodule : rdds_top

//--- include/rdds_pkg.sv
// Shared constants and types of the receiver data sequencer.
// Assumes a single crystal-derived clock domain.
package rdds_pkg;

   // Base tick dividers, stored as terminal counts (factor minus one)
   localparam logic [3:0] DIV_BAND_LO_M1 = 4'h9;
   localparam logic [3:0] DIV_BAND_HI_M1 = 4'hd;

   // Extended tick terminal counts in base ticks, per rate range
   localparam logic [2:0] EXT_R0_M1 = 3'h7;
   localparam logic [2:0] EXT_R1_M1 = 3'h3;
   localparam logic [2:0] EXT_R2_M1 = 3'h1;
   localparam logic [2:0] EXT_R3_M1 = 3'h0;

   // Wake time in base ticks, half ticks rounded up
   localparam logic [9:0] WAKE_R0 = 10'h381;
   localparam logic [9:0] WAKE_R1 = 10'h201;
   localparam logic [9:0] WAKE_R3 = 10'h141;

   localparam logic       IDLE_LVL   = 1'b1;
   localparam logic [3:0] MIN_EE_DEF = 4'h2;
   localparam logic [1:0] RANGE_RST  = 2'h0;

   typedef logic [1:0] rdds_range_t;

   typedef enum logic [2:0] {
      ST_SLEEP = 3'b001,
      ST_WAKE  = 3'b010,
      ST_RX    = 3'b100
   } rdds_state_e;

   function automatic logic [9:0] rdds_wake_term(input rdds_range_t r);
      logic [9:0] t;
      t = WAKE_R0;
      unique case (r)
         2'h0: t = WAKE_R0;
         2'h1: t = WAKE_R1;
         2'h2: t = WAKE_R1;
         2'h3: t = WAKE_R3;
      endcase
      return t;
   endfunction : rdds_wake_term

endpackage : rdds_pkg

//--- include/rdds_tick_if.sv
// Tick carrier between the sequencer and its tick generator.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
interface rdds_tick_if;
   import rdds_pkg::*;
   logic        band;
   logic        run;
   rdds_range_t range;
   logic        base_tick;
   logic        ext_tick;

   modport gen (input band, input run, input range, output base_tick, output ext_tick);
   modport sink (output band, output run, output range, input base_tick, input ext_tick);
endinterface : rdds_tick_if

//--- rtl/rdds_tick_gen.sv
// Base tick divider and extended tick scaler.
// Assumes band and range come already synchronised to mclk.
`timescale 1ns/1ps
module rdds_tick_gen
   import rdds_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   rdds_tick_if.gen tk
);

   logic [3:0] div_q;
   logic [2:0] ext_q;
   logic [3:0] div_lim;
   logic [2:0] ext_lim;
   logic [3:0] gap_q;
   logic       seen_q;
   logic [2:0] bcnt_q;
   logic       eseen_q;

   assign div_lim = tk.band ? DIV_BAND_HI_M1 : DIV_BAND_LO_M1;

   always_comb begin
      ext_lim = EXT_R0_M1;
      unique case (tk.range)
         2'h0: ext_lim = EXT_R0_M1;
         2'h1: ext_lim = EXT_R1_M1;
         2'h2: ext_lim = EXT_R2_M1;
         2'h3: ext_lim = EXT_R3_M1;
      endcase
   end

   assign tk.base_tick = clk_en & tk.run & (div_q == div_lim);
   assign tk.ext_tick  = tk.base_tick & (ext_q >= ext_lim);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 4'h0;
      end else if (clk_en) begin
         if (!tk.run || tk.base_tick) begin
            div_q <= 4'h0;
         end else begin
            div_q <= div_q + 4'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ext_q <= 3'h0;
      end else if (clk_en) begin
         if (!tk.run || tk.ext_tick) begin
            ext_q <= 3'h0;
         end else if (tk.base_tick) begin
            ext_q <= ext_q + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checking helpers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gap_q   <= 4'h0;
         seen_q  <= 1'b0;
         bcnt_q  <= 3'h0;
         eseen_q <= 1'b0;
      end else if (clk_en) begin
         seen_q  <= tk.run & (seen_q | tk.base_tick);
         gap_q   <= (tk.base_tick || !tk.run) ? 4'h0 : gap_q + 4'h1;
         eseen_q <= tk.run & (eseen_q | tk.ext_tick);
         if (tk.ext_tick || !tk.run) begin
            bcnt_q <= 3'h0;
         end else if (tk.base_tick) begin
            bcnt_q <= bcnt_q + 3'h1;
         end
      end
   end

   AST_BASE_DIV: assert property (@(posedge mclk) disable iff (!rst_n)
      (tk.base_tick && seen_q) |-> gap_q == (tk.band ? 4'hd : 4'h9))
      else $error("base tick spacing does not match band divider");

   AST_EXT_RATIO: assert property (@(posedge mclk) disable iff (!rst_n)
      (tk.ext_tick && eseen_q && $stable(tk.range)) |->
         bcnt_q == (3'h7 >> tk.range))
      else $error("extended tick ratio wrong for range");

   AST_EXT_ON_BASE: assert property (@(posedge mclk) disable iff (!rst_n)
      tk.ext_tick |-> tk.base_tick && tk.run)
      else $error("extended tick not aligned to base tick");

endmodule : rdds_tick_gen

//--- sim/rdds_mcu_model.sv
// Consumer model standing for the controller that reads the data stream.
// Assumes a single mclk domain; stall_pct sets how often it is not ready.
`timescale 1ns/1ps
module rdds_mcu_model (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [6:0] stall_pct,
   output logic            out_ready
);
   // Ready redrawn each cycle, so stalls come at any phase
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) out_ready <= 1'b0;
      else out_ready <= ($urandom_range(99) >= stall_pct);
   end
endmodule : rdds_mcu_model

//--- sim/rdds_top_tb.sv
// Self-checking bench of the receiver data sequencer.
// Assumes the design package and the consumer model are compiled first.
`timescale 1ns/1ps
module rdds_top_tb;
   import rdds_pkg::*;
   localparam logic [3:0] MIN_EE = 4'h4;
   logic        mclk, rst_n, clk_en, band_sel, rate_sel_hi, rate_sel_lo;
   logic        enable, dem_in, out_ready, data_out, out_valid, rx_active;
   rdds_range_t lp_corner;
   logic [6:0]  stall_pct;
   logic        last_word, held_vld, held_word, armed, run_ok;
   int          failures, n_tests, cyc, n_pops, last_pop, run, seed;

   rdds_top #(.MIN_EE_TICKS(MIN_EE)) i_rdds_top (.mclk(mclk), .rst_n(rst_n),
      .clk_en(clk_en), .band_sel(band_sel), .rate_sel_hi(rate_sel_hi),
      .rate_sel_lo(rate_sel_lo), .enable(enable), .dem_in(dem_in),
      .out_ready(out_ready), .data_out(data_out), .out_valid(out_valid),
      .rx_active(rx_active), .lp_corner(lp_corner));
   rdds_mcu_model i_rdds_mcu_model (.mclk(mclk), .rst_n(rst_n),
      .stall_pct(stall_pct), .out_ready(out_ready));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   task automatic report_and_stop;
      if (failures == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step

   task automatic wait_pops(input int n);
      int target;
      int k;
      target = n_pops + n;
      for (k = 0; k < 5000 && n_pops < target; k++) step(1);
      chk("pop_wait", 1, n_pops >= target);
   endtask : wait_pops

   function automatic int exp_range(input logic h, input logic l);
      return h ? 2 : (l ? 1 : 0);
   endfunction : exp_range

   function automatic int wake_ticks(input int r);
      return (r == 0) ? 897 : ((r == 3) ? 321 : 513);
   endfunction : wake_ticks

   function automatic int ext_len(input int r);
      return 8 >> r;
   endfunction : ext_len

   ////////////////////////////////////////////////////////////////////////
   // Stream monitor: held words, edge spacing of popped words
   always @(posedge mclk) begin
      cyc++;
      if (held_vld) chk("held_word", {1'b1, held_word}, {out_valid, data_out});
      held_vld = rst_n && enable && out_valid === 1'b1 && !out_ready;
      held_word = data_out;
      if (rst_n && clk_en && out_valid === 1'b1 && out_ready) begin
         n_pops++;
         last_pop = cyc;
         if (data_out === last_word) run++;
         else begin
            if (run_ok) chk("edge_gap", 1, run >= MIN_EE);
            run_ok = armed;
            armed = 1'b1;
            run = 1;
            last_word = data_out;
         end
      end
   end

   task automatic run_cfg(input logic b, input logic h, input logic l);
      int r, div, t0, p0, k;
      r = exp_range(h, l);
      div = b ? 14 : 10;
      band_sel = b;
      rate_sel_hi = h;
      rate_sel_lo = l;
      stall_pct = 7'd0;
      step(6);
      chk("lp_corner", r, lp_corner);
      armed = 1'b0;
      run_ok = 1'b0;
      last_word = 1'b1;
      for (k = 0; k < 30; k++) begin
         dem_in = 1'($urandom_range(1));
         step(3);
         chk("sleep", 3'b100, {data_out, out_valid, rx_active});
      end
      dem_in = 1'b1;
      enable = 1'b1;
      t0 = cyc;
      for (k = 0; k < 20000 && rx_active !== 1'b1; k++) step(1);
      chk("wake_min", 1, (cyc - t0) >= wake_ticks(r) * div);
      chk("wake_max", 1, (cyc - t0) <= wake_ticks(r) * div + div + 6);
      step(ext_len(r) * div * 3);
      chk("wait_fall", 0, out_valid);
      dem_in = 1'b0;
      wait_pops(1);
      chk("first_word", 0, last_word);
      wait_pops(1);
      p0 = last_pop;
      wait_pops(1);
      chk("tick_span", ext_len(r) * div, last_pop - p0);
      stall_pct = 7'd50;
      for (k = 0; k < 40; k++) begin
         dem_in = ~dem_in;
         step($urandom_range(ext_len(r) * div * 3, 1));
      end
      stall_pct = 7'd100;
      step(ext_len(r) * div * 6);
      chk("full_hold", 1, out_valid);
      // Clock enable low must freeze ticks, buffer and debounce
      p0 = {data_out, out_valid};
      clk_en = 1'b0;
      dem_in = ~dem_in;
      step(ext_len(r) * div * 2);
      chk("freeze", p0, {data_out, out_valid});
      clk_en = 1'b1;
      stall_pct = 7'd0;
      wait_pops(2);
      enable = 1'b0;
      step(5);
      chk("back_asleep", 3'b100, {data_out, out_valid, rx_active});
   endtask : run_cfg

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, band_sel, rate_sel_hi, rate_sel_lo, enable} = 5'h00;
      {clk_en, dem_in, last_word, held_word} = 4'hf;
      {armed, run_ok, held_vld} = 3'h0;
      stall_pct = 7'd0;
      {failures, n_tests, cyc, n_pops, last_pop, run} = {6{32'h0}};
      seed = $urandom(32'h42c7);
      step(3);
      rst_n = 1'b1;
      chk("reset", 5'h10, {data_out, out_valid, rx_active, lp_corner});
      run_cfg(1'b0, 1'b0, 1'b0);
      run_cfg(1'b1, 1'b0, 1'b1);
      run_cfg(1'b0, 1'b1, 1'b0);
      run_cfg(1'b1, 1'b1, 1'b1);
      report_and_stop();
   end

   initial begin
      #1_000_000;
      failures++;
      report_and_stop();
   end
endmodule : rdds_top_tb
